// ---- pkg/crtv_pkg.sv ----
// types of the vertical timing block
package crtv_pkg;
  typedef enum logic {CRTV_ROWS, CRTV_ADJUST} crtv_vphase_t;

  typedef struct packed {
    logic [4:0] idx;
    logic [7:0] htot;
    logic [7:0] hdisp;
    logic [7:0] hspos;
    logic [7:0] widths;
    logic [6:0] vtot;
    logic [4:0] vadj;
    logic [6:0] vdisp;
    logic [6:0] vspos;
    logic [7:0] mode;
    logic [4:0] maxra;
    logic [7:0] hcnt;
    logic [3:0] hs_cnt;
    logic hs;
    logic [4:0] ra;
    logic [6:0] row;
    crtv_vphase_t vph;
    logic [4:0] adj_cnt;
    logic odd;
    logic vs_arm;
    logic [4:0] vs_cnt;
    logic vs;
    logic [1:0] den_pipe;
    logic [1:0] cur_pipe;
    logic den_o;
    logic cur_o;
  } crtv_state_t;
endpackage

// ---- pkg/crtv_regs.svh ----
// register indices, field positions, reset values and codes of the vertical timing block
//
// Operation
// - line sync width low nibble, 1 to 15
// - frame sync width high nibble, zero means sixteen
// - vertical total holds rows per frame minus one
// - adjust rasters appended after last row
// - displayed rows gate display enable
// - sync row holds start row, counted from zero
// - larger sync row moves picture upward
// - bits 1:0 select normal or interlace modes
// - interlace places odd field rasters midway
// - sync and video shows different rasters per field
// - bits 5:4 set display enable delay
// - bits 7:6 set cursor delay
// - cursor and enable delayed independently
// - raster count minus one, or minus two
// - line total minus one, even for interlace
// - line sync starts at programmed position
`ifndef CRTV_REGS_SVH
`define CRTV_REGS_SVH

// =====================================================
// register indices
`define CRTV_IDX_LINE_TOTAL 5'h00
`define CRTV_IDX_LINE_SHOWN 5'h01
`define CRTV_IDX_LINE_SYNC 5'h02
`define CRTV_IDX_SYNC_WIDTHS 5'h03
`define CRTV_IDX_VTOTAL 5'h04
`define CRTV_IDX_VADJUST 5'h05
`define CRTV_IDX_VSHOWN 5'h06
`define CRTV_IDX_VSYNC_ROW 5'h07
`define CRTV_IDX_MODE_SKEW 5'h08
`define CRTV_IDX_RASTERS 5'h09

// =====================================================
// field positions
`define CRTV_MODE_S_BIT 0
`define CRTV_MODE_V_BIT 1
`define CRTV_DEN_SKEW_LSB 4
`define CRTV_CUR_SKEW_LSB 6

// =====================================================
// reset values and codes
`define CRTV_RST_BYTE 8'h00
`define CRTV_SKEW_NONE 2'h0
`define CRTV_SKEW_ONE 2'h1
`define CRTV_SKEW_TWO 2'h2
`define CRTV_SKEW_OFF 2'h3
`define CRTV_VSW_ZERO_LEN 5'h10

`endif

// ---- test/crtv_host.sv ----
// host bus model writing the timing registers
`timescale 1ns/1ns
`default_nettype none
module crtv_host (
  input wire logic clock,
  output logic bus_cs_b,
  output logic bus_rs,
  output logic bus_wr,
  output logic [7:0] bus_wdata
);
  initial begin
    bus_cs_b = 1'b1;
    bus_rs = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
  end
  // ==========================================
  // index write, then data write
  task automatic put(input logic [4:0] idx, input logic [7:0] val);
    @(posedge clock);
    #1;
    {bus_cs_b, bus_rs, bus_wr, bus_wdata} = {3'b001, 3'h0, idx};
    @(posedge clock);
    #1;
    {bus_rs, bus_wdata} = {1'b1, val};
    @(posedge clock);
    #1;
    {bus_cs_b, bus_wr, bus_wdata} = {2'b10, ~val};
  endtask
endmodule // crtv_host
`default_nettype wire

// ---- test/crtv_top_bench.sv ----
// self-checking bench of the vertical timing block
`timescale 1ns/1ns
`default_nettype none
`include "crtv_regs.svh"
module crtv_top_bench;
  logic clock = 1'b0, rst_b = 1'b0, char_clk_en = 1'b1, cursor_req = 1'b0;
  wire logic bus_cs_b, bus_rs, bus_wr, line_sync_out, frame_sync_out, den_out, cursor_out, odd_field;
  wire logic [7:0] bus_wdata;
  wire logic [4:0] raster_addr;
  wire logic [6:0] row_addr;
  int n_fail = 0, cmp_count = 0, cyc = 0, per, vw, hw, dc, dp, cp, cq = -5, dp0, cp0, d3;
  logic [4:0] ra0;
  logic [6:0] rw0;
  logic od, od0;
  logic [3:0] pv;
  logic [7:0] wt [3] = '{8'h02, 8'h35, 8'hf7};
  logic [7:0] vt [3] = '{8'h09, 8'h05, 8'h04};
  logic [7:0] ad [3] = '{8'h01, 8'h00, 8'h1f};
  logic [7:0] rn [3] = '{8'h01, 8'h02, 8'h01};
  logic [7:0] sk [4] = '{8'h50, 8'h90, 8'h60, 8'hf0};
  always #5 clock = ~clock;
  crtv_host host (.clock(clock), .bus_cs_b(bus_cs_b), .bus_rs(bus_rs), .bus_wr(bus_wr), .bus_wdata(bus_wdata));
  crtv_top dut (.clock(clock), .rst_b(rst_b), .char_clk_en(char_clk_en), .bus_cs_b(bus_cs_b),
    .bus_rs(bus_rs), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .cursor_req(cursor_req),
    .line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out), .den_out(den_out),
    .cursor_out(cursor_out), .raster_addr(raster_addr), .row_addr(row_addr), .odd_field(odd_field));
  // ==========================================
  // checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end
  // ==========================================
  // field measurement between frame sync rises
  task automatic step();
    pv = {frame_sync_out, den_out, cursor_out, 1'b0};
    @(posedge clock);
    #1;
  endtask
  task automatic meas();
    int t;
    for (t = 0; t < 2; t++) begin
      per = 0;
      step();
      while (!(frame_sync_out && !pv[3]) && per < 3000) begin
        step();
        per++;
      end
    end
    od = odd_field;
    dp = -1;
    cp = -1;
    per = 0;
    vw = 0;
    hw = 0;
    dc = 0;
    do begin
      cursor_req = (per == cq);
      vw += frame_sync_out;
      hw += line_sync_out;
      dc += den_out;
      if (den_out && !pv[2] && dp < 0) begin
        dp = per;
        ra0 = raster_addr;
        rw0 = row_addr;
      end
      if (cursor_out && !pv[1] && cp < 0)
        cp = per;
      per++;
      step();
    end while (!(frame_sync_out && !pv[3]) && per < 3000);
  endtask
  task automatic cfg(input logic [7:0] t, input logic [7:0] a, input logic [7:0] r);
    host.put(`CRTV_IDX_VTOTAL, t);
    host.put(`CRTV_IDX_VADJUST, a);
    host.put(`CRTV_IDX_RASTERS, r);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    #1;
    rst_b = 1'b1;
    host.put(`CRTV_IDX_LINE_TOTAL, 8'h07);
    host.put(`CRTV_IDX_LINE_SHOWN, 8'h04);
    host.put(`CRTV_IDX_LINE_SYNC, 8'h05);
    host.put(`CRTV_IDX_VSHOWN, 8'h02);
    host.put(`CRTV_IDX_VSYNC_ROW, 8'h03);
    cfg(8'h09, 8'h01, 8'h01);
    foreach (wt[i]) begin
      host.put(`CRTV_IDX_SYNC_WIDTHS, wt[i]);
      meas();
      chk(vw, (wt[i][7:4] == 4'h0 ? 16 : wt[i][7:4]) * 8);
      chk(hw, wt[i][3:0] * 21);
    end
    host.put(`CRTV_IDX_SYNC_WIDTHS, 8'h12);
    foreach (vt[i]) begin
      cfg(vt[i], ad[i], rn[i]);
      meas();
      chk(per, ((vt[i] + 1) * (rn[i] + 1) + ad[i]) * 8);
      chk(dc, 2 * (rn[i] + 1) * 4);
    end
    cfg(8'h09, 8'h01, 8'h01);
    host.put(5'd20, 8'h00);
    meas();
    chk(per, 168);
    chk(rw0, 7'h00);
    d3 = dp;
    host.put(`CRTV_IDX_VSYNC_ROW, 8'h04);
    meas();
    chk(d3 - dp, 16);
    host.put(`CRTV_IDX_VSYNC_ROW, 8'h03);
    meas();
    dp0 = dp;
    cq = dp0 + 1;
    meas();
    cp0 = cp;
    foreach (sk[i]) begin
      host.put(`CRTV_IDX_MODE_SKEW, sk[i]);
      meas();
      chk(dp, sk[i][5:4] == 2'h3 ? -1 : dp0 + sk[i][5:4]);
      chk(cp, sk[i][7:6] == 2'h3 ? -1 : cp0 + sk[i][7:6]);
    end
    host.put(`CRTV_IDX_MODE_SKEW, 8'h00);
    meas();
    chk(od, 1'b0);
    host.put(`CRTV_IDX_MODE_SKEW, 8'h01);
    meas();
    od0 = od;
    chk(ra0, 5'h00);
    meas();
    chk(od0 ^ od, 1'b1);
    chk(ra0, 5'h00);
    host.put(`CRTV_IDX_RASTERS, 8'h02);
    host.put(`CRTV_IDX_MODE_SKEW, 8'h03);
    meas();
    chk(ra0, {4'h0, ~od});
    chk(dc, 16);
    meas();
    chk(ra0, {4'h0, ~od});
    summarize();
  end
endmodule // crtv_top_bench
`default_nettype wire

// ---- verilog/crtv_top.sv ----
// vertical timing, sync widths, scan modes and skew of the display controller
`timescale 1ns/1ns
`default_nettype none
`include "crtv_regs.svh"

module crtv_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic char_clk_en,
  input wire logic bus_cs_b,
  input wire logic bus_rs,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  input wire logic cursor_req,
  output logic line_sync_out,
  output logic frame_sync_out,
  output logic den_out,
  output logic cursor_out,
  output logic [4:0] raster_addr,
  output logic [6:0] row_addr,
  output logic odd_field
);

  crtv_pkg::crtv_state_t q, n;
  logic line_end;
  logic half_pt;
  logic row_last;
  logic new_field;
  logic ilace;
  logic video;
  logic vs_line;
  logic den_raw;
  logic [4:0] step;
  logic [4:0] first_ra;
  logic [1:0] den_skew;
  logic [1:0] cur_skew;

  // =====================================================
  // next state
  always_comb begin
    n = q;
    ilace = q.mode[`CRTV_MODE_S_BIT];
    video = ilace & q.mode[`CRTV_MODE_V_BIT];
    den_skew = q.mode[`CRTV_DEN_SKEW_LSB +: 2];
    cur_skew = q.mode[`CRTV_CUR_SKEW_LSB +: 2];
    step = video ? 5'h02 : 5'h01;
    line_end = (q.hcnt == q.htot);
    half_pt = (q.hcnt == {1'b0, q.htot[7:1]});
    row_last = video ? (q.ra >= q.maxra) : (q.ra == q.maxra);
    new_field = 1'b0;
    vs_line = 1'b0;
    first_ra = 5'h00;
    den_raw = (q.hcnt < q.hdisp) && (q.row < q.vdisp) && (q.vph == crtv_pkg::CRTV_ROWS);

    // register writes through the index register
    if (bus_wr && !bus_cs_b) begin
      if (!bus_rs) begin
        n.idx = bus_wdata[4:0];
      end else begin
        case (q.idx)
          `CRTV_IDX_LINE_TOTAL: n.htot = bus_wdata;
          `CRTV_IDX_LINE_SHOWN: n.hdisp = bus_wdata;
          `CRTV_IDX_LINE_SYNC: n.hspos = bus_wdata;
          `CRTV_IDX_SYNC_WIDTHS: n.widths = bus_wdata;
          `CRTV_IDX_VTOTAL: n.vtot = bus_wdata[6:0];
          `CRTV_IDX_VADJUST: n.vadj = bus_wdata[4:0];
          `CRTV_IDX_VSHOWN: n.vdisp = bus_wdata[6:0];
          `CRTV_IDX_VSYNC_ROW: n.vspos = bus_wdata[6:0];
          `CRTV_IDX_MODE_SKEW: n.mode = bus_wdata;
          `CRTV_IDX_RASTERS: n.maxra = bus_wdata[4:0];
          default: begin
          end
        endcase
      end
    end

    if (char_clk_en) begin
      // character counter
      n.hcnt = line_end ? 8'h00 : q.hcnt + 8'h01;

      // line sync pulse
      if (q.hs) begin
        if (q.hs_cnt == 4'h0) begin
          n.hs = 1'b0;
        end else begin
          n.hs_cnt = q.hs_cnt - 4'h1;
        end
      end
      if (q.hcnt == q.hspos) begin
        n.hs = 1'b1;
        n.hs_cnt = q.widths[3:0] - 4'h1;
      end

      // vertical sequence
      if (line_end) begin
        case (q.vph)
          crtv_pkg::CRTV_ROWS: begin
            if (row_last) begin
              if (q.row == q.vtot) begin
                if (q.vadj == 5'h00) begin
                  new_field = 1'b1;
                end else begin
                  n.vph = crtv_pkg::CRTV_ADJUST;
                  n.adj_cnt = 5'h00;
                  n.ra = 5'h00;
                end
              end else begin
                n.row = q.row + 7'h01;
                n.ra = (video && q.odd) ? 5'h01 : 5'h00;
              end
            end else begin
              n.ra = q.ra + step;
            end
          end
          crtv_pkg::CRTV_ADJUST: begin
            if (q.adj_cnt == q.vadj - 5'h01) begin
              new_field = 1'b1;
            end else begin
              n.adj_cnt = q.adj_cnt + 5'h01;
              n.ra = q.ra + 5'h01;
            end
          end
          default: begin
            new_field = 1'b1;
          end
        endcase
        if (new_field) begin
          n.vph = crtv_pkg::CRTV_ROWS;
          n.row = 7'h00;
          n.adj_cnt = 5'h00;
          n.odd = ilace ? ~q.odd : 1'b0;
          n.ra = (video && !q.odd) ? 5'h01 : 5'h00;
        end
        first_ra = (video && n.odd) ? 5'h01 : 5'h00;
        // later sync row shifts the picture up
        vs_line = (n.vph == crtv_pkg::CRTV_ROWS) && (n.row == q.vspos) && (n.ra == first_ra);
      end

      // frame sync pulse, half a line late in an odd interlaced field
      if (q.vs && ((ilace && q.odd) ? half_pt : line_end)) begin
        if (q.vs_cnt == 5'h01) begin
          n.vs = 1'b0;
        end
        n.vs_cnt = q.vs_cnt - 5'h01;
      end
      if (q.vs_arm && half_pt) begin
        n.vs_arm = 1'b0;
      end
      if ((q.vs_arm && half_pt) || (vs_line && !(ilace && n.odd))) begin
        n.vs = 1'b1;
        n.vs_cnt = (q.widths[7:4] == 4'h0) ? `CRTV_VSW_ZERO_LEN : {1'b0, q.widths[7:4]};
      end else if (vs_line) begin
        n.vs_arm = 1'b1;
      end

      // independent skew of enable and cursor
      n.den_pipe = {q.den_pipe[0], den_raw};
      n.cur_pipe = {q.cur_pipe[0], cursor_req};
      case (den_skew)
        `CRTV_SKEW_NONE: n.den_o = den_raw;
        `CRTV_SKEW_ONE: n.den_o = q.den_pipe[0];
        `CRTV_SKEW_TWO: n.den_o = q.den_pipe[1];
        default: n.den_o = 1'b0;
      endcase
      case (cur_skew)
        `CRTV_SKEW_NONE: n.cur_o = cursor_req;
        `CRTV_SKEW_ONE: n.cur_o = q.cur_pipe[0];
        `CRTV_SKEW_TWO: n.cur_o = q.cur_pipe[1];
        default: n.cur_o = 1'b0;
      endcase
    end
  end

  // =====================================================
  // state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign line_sync_out = q.hs;
  assign frame_sync_out = q.vs;
  assign den_out = q.den_o;
  assign cursor_out = q.cur_o;
  assign raster_addr = q.ra;
  assign row_addr = q.row;
  assign odd_field = q.odd;

  // =====================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  index_write_a: assert property (bus_wr && !bus_cs_b && !bus_rs |=> q.idx == $past(bus_wdata[4:0]))
    else $error("index register not loaded");
  line_sync_pos_a: assert property ($rose(q.hs) |-> $past(q.hcnt) == $past(q.hspos))
    else $error("line sync started off position");
  line_sync_len_a: assert property ($rose(q.hs) |-> q.hs_cnt == $past(q.widths[3:0]) - 4'h1)
    else $error("line sync width wrong");
  frame_sync_len_a: assert property ($rose(q.vs) |->
      q.vs_cnt == (($past(q.widths[7:4]) == 4'h0) ? 5'h10 : {1'b0, $past(q.widths[7:4])}))
    else $error("frame sync width wrong");
  frame_sync_row_a: assert property ($rose(q.vs) && !q.odd |-> q.row == q.vspos && q.vph == crtv_pkg::CRTV_ROWS)
    else $error("frame sync outside its row");
  adjust_entry_a: assert property (char_clk_en && line_end && q.vph == crtv_pkg::CRTV_ROWS && row_last
      && q.row == q.vtot && q.vadj != 5'h00 |=> q.vph == crtv_pkg::CRTV_ADJUST)
    else $error("adjust rasters skipped");
  adjust_exit_a: assert property (char_clk_en && line_end && q.vph == crtv_pkg::CRTV_ADJUST
      && q.adj_cnt == q.vadj - 5'h01 |=> q.vph == crtv_pkg::CRTV_ROWS && q.row == 7'h00)
    else $error("adjust length wrong");
  den_off_a: assert property (char_clk_en && den_skew == 2'h3 |=> !q.den_o)
    else $error("display enable not suppressed");
  cursor_skew_a: assert property (char_clk_en && cur_skew == 2'h2 |=> q.cur_o == $past(q.cur_pipe[1]))
    else $error("cursor skew wrong");
  video_step_a: assert property (char_clk_en && line_end && video && q.vph == crtv_pkg::CRTV_ROWS
      && !row_last |=> q.ra == $past(q.ra) + 5'h02)
    else $error("raster step wrong");
  field_flip_a: assert property (char_clk_en && new_field |=> q.odd == ($past(ilace) ? !$past(q.odd) : 1'b0))
    else $error("field parity wrong");

endmodule // crtv_top
`default_nettype wire
